// file: logic/ctrl_port_pkg.sv
// Constants and types shared by the dual-mode control port
package ctrl_port_pkg;

  // ****************************************
  // Addresses and pointer layout
  // ****************************************
  localparam logic [6:0] SPI_CHIP_ADDR = 7'h10;
  localparam logic [3:0] I2C_ADDR_HIGH = 4'h2;
  localparam int PTR_POINTER_AUTO_ADVANCE_BIT = 7;
  localparam logic [7:0] PTR_RESET = 8'h00;

  // ****************************************
  // Bit counting
  // ****************************************
  localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
  localparam logic [3:0] I2C_ACK_SLOT = 4'h8;

  // ****************************************
  // Transfer phases and port state
  // ****************************************
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_PTR, ST_WDATA, ST_READ, ST_WAIT} phase_type;

  typedef struct packed {
    logic spi;
    logic a2;
    logic sel_prev;
    logic sclk_prev;
    logic sda_prev;
    phase_type st;
    logic [3:0] cnt;
    logic [7:0] sh_in;
    logic [7:0] sh_out;
    logic [7:0] ptr;
    logic ack;
    logic out;
    logic oe;
    logic wr;
    logic rd;
    logic [6:0] waddr;
    logic [7:0] wdata;
  } port_state_type;

endpackage

// file: logic/pin_sync.sv
// Two-flop synchroniser for pins arriving from outside the core clock
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock
  input wire logic core_clk_i,
  // Pins in and synchronised levels out
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] level_q;

  // No reset: the strap must keep flowing through while reset is held
  always_ff @(posedge core_clk_i)
  begin
    meta_q <= pin_i;
    level_q <= meta_q;
  end

  assign level_o = level_q;

endmodule
`default_nettype wire

// file: logic/dual_mode_control_port.sv
// Dual-mode SPI / I2C slave control port with register pointer
//
// Contract
// - Select falling after reset picks SPI; a static select pin means I2C, level is A0.
// - SPI samples input on bit clock rise, changes output on fall.
// - SPI write: byte after direction loads pointer, next byte goes to register.
// - Serial data output stays high impedance throughout SPI writes.
// - Pointer holds when auto-advance is zero, else steps after each byte.
// - SPI read: next bit clock fall drives MSB of addressed register.
// - SPI read with auto-advance streams successive registers while clocked.
// - I2C uses no select; data on SDA, clocked by host SCL.
// - I2C address is 0010b, then strap A2, A1 pin, A0 pin.
// - Address bit two is caught from the strap pin while reset is held.
// - I2C write: byte after address loads pointer, later bytes write registers.
// - I2C read returns pointed register, continuing when auto-advance is set.
// - Device drives acknowledge after every byte it receives over I2C, except an address byte that is not its own.
// - Port runs asynchronously to audio clocks; idle pins should stay static.
// - Pointer byte MSB first; bit 7 auto-advance, bits 6..0 register address.
`timescale 1ns/1ns
`default_nettype none
module dual_mode_control_port
  import ctrl_port_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Link pins
  input wire logic select_or_addr_bit0_pin_i,
  input wire logic serial_bit_clock_i,
  input wire logic serial_data_in_i,
  input wire logic serial_data_out_i,
  output logic serial_data_out_o,
  output logic serial_data_out_oe_o,
  // Address straps
  input wire logic addr_bit1_pin_i,
  input wire logic preemphasis_strap_pin_i,
  // Register file side
  output logic [6:0] reg_addr_o,
  output logic pointer_auto_advance_o,
  input wire logic [7:0] reg_rdata_i,
  output logic reg_rd_o,
  output logic reg_wr_o,
  output logic [6:0] reg_waddr_o,
  output logic [7:0] reg_wdata_o,
  // Status
  output logic spi_mode_o
);

  // ****************************************
  // Helpers
  // ****************************************

  // Step the register address only when auto-advance is set
  function automatic logic [7:0] next_ptr(input logic [7:0] p);
    next_ptr = p[PTR_POINTER_AUTO_ADVANCE_BIT] ? {p[7], p[6:0] + 7'h01} : p;
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [5:0] pins_s;
  logic sel_s;
  logic sclk_s;
  logic sdi_s;
  logic sda_s;
  logic ad1_s;
  logic strap_s;

  pin_sync #(.WIDTH(6)) u_sync (
    .core_clk_i(core_clk_i),
    .pin_i({preemphasis_strap_pin_i, addr_bit1_pin_i, serial_data_out_i,
            serial_data_in_i, serial_bit_clock_i, select_or_addr_bit0_pin_i}),
    .level_o(pins_s)
  );

  assign sel_s = pins_s[0];
  assign sclk_s = pins_s[1];
  assign sdi_s = pins_s[2];
  assign sda_s = pins_s[3];
  assign ad1_s = pins_s[4];
  assign strap_s = pins_s[5];

  // ****************************************
  // Edge and condition decode
  // ****************************************
  port_state_type st_q;
  port_state_type st_d;
  logic sel_fall;
  logic sclk_rise;
  logic sclk_fall;
  logic i2c_start;
  logic i2c_stop;
  logic rx_state;
  logic take;
  logic byte_done;
  logic tx_fall;
  logic addr_match;
  logic [7:0] rx_byte;
  logic [7:0] tx;

  // Edges come from the settled copies, so a pin edge shows once
  assign sel_fall = st_q.sel_prev & ~sel_s;
  assign sclk_rise = ~st_q.sclk_prev & sclk_s;
  assign sclk_fall = st_q.sclk_prev & ~sclk_s;
  assign i2c_start = ~st_q.spi & st_q.sclk_prev & sclk_s & st_q.sda_prev & ~sda_s;
  assign i2c_stop = ~st_q.spi & st_q.sclk_prev & sclk_s & ~st_q.sda_prev & sda_s;
  assign rx_state = (st_q.st == ST_ADDR) | (st_q.st == ST_PTR) | (st_q.st == ST_WDATA);
  assign rx_byte = {st_q.sh_in[6:0], st_q.spi ? sdi_s : sda_s};
  // Incoming bits are counted only on bit clock rises
  assign take = sclk_rise & rx_state & (st_q.spi ? ~sel_s : (st_q.cnt != I2C_ACK_SLOT));
  assign byte_done = take & (st_q.cnt[2:0] == BYTE_LAST_BIT);
  // Outgoing bits change on bit clock falls
  assign tx_fall = sclk_fall & (st_q.st == ST_READ) & (st_q.spi ? ~sel_s : (st_q.cnt != I2C_ACK_SLOT));
  assign addr_match = st_q.spi ? (rx_byte[7:1] == SPI_CHIP_ADDR)
                               : (rx_byte[7:1] == {I2C_ADDR_HIGH, st_q.a2, ad1_s, sel_s});
  assign tx = (st_q.cnt[2:0] == 3'h0) ? reg_rdata_i : st_q.sh_out;

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb
  begin
    st_d = st_q;
    st_d.wr = 1'b0;
    st_d.rd = 1'b0;
    st_d.sel_prev = sel_s;
    st_d.sclk_prev = sclk_s;
    st_d.sda_prev = sda_s;
    if (sys_rst_i)
    begin
      st_d = '0;
      st_d.st = ST_IDLE;
      st_d.ptr = PTR_RESET;
      st_d.a2 = strap_s;
      st_d.sel_prev = sel_s;
      st_d.sclk_prev = sclk_s;
      st_d.sda_prev = sda_s;
    end
    else
    begin
      // A select edge means a master is driving it, so SPI locks in
      if (sel_fall)
      begin
        st_d.spi = 1'b1;
        st_d.st = ST_ADDR;
        st_d.cnt = 4'h0;
        st_d.oe = 1'b0;
      end
      // Receive path shared by both modes
      if (take)
      begin
        st_d.sh_in = rx_byte;
        st_d.cnt = (byte_done && st_q.spi) ? 4'h0 : st_q.cnt + 4'h1;
      end
      if (byte_done)
      begin
        st_d.ack = ~st_q.spi;
        unique case (st_q.st)
          ST_ADDR:
          begin
            if (!addr_match)
            begin
              st_d.st = ST_WAIT;
              st_d.ack = 1'b0;
            end
            else
              st_d.st = rx_byte[0] ? ST_READ : ST_PTR;
          end
          ST_PTR:
          begin
            st_d.ptr = rx_byte;
            st_d.st = ST_WDATA;
          end
          ST_WDATA:
          begin
            st_d.wr = 1'b1;
            st_d.waddr = st_q.ptr[6:0];
            st_d.wdata = rx_byte;
            st_d.ptr = next_ptr(st_q.ptr);
          end
          default:
          begin
          end
        endcase
      end
      // Transmit path; a byte is fetched when its first bit goes out
      if (tx_fall)
      begin
        if (st_q.cnt[2:0] == 3'h0)
        begin
          st_d.rd = 1'b1;
          st_d.ptr = next_ptr(st_q.ptr);
        end
        st_d.sh_out = {tx[6:0], 1'b0};
        st_d.out = st_q.spi ? tx[7] : 1'b0;
        st_d.oe = st_q.spi | ~tx[7];
        if (st_q.spi)
          st_d.cnt = {1'b0, st_q.cnt[2:0] + 3'h1};
      end
      if (st_q.spi)
      begin
        // Releasing select drops any half-shifted byte
        if (sel_s)
        begin
          st_d.st = ST_ADDR;
          st_d.cnt = 4'h0;
          st_d.oe = 1'b0;
        end
      end
      else
      begin
        // Ninth clock: acknowledge slot in either direction
        if (sclk_rise && st_q.cnt == I2C_ACK_SLOT && st_q.st != ST_IDLE && st_q.st != ST_WAIT)
        begin
          st_d.cnt = 4'h0;
          if (st_q.st == ST_READ && sda_s)
            st_d.st = ST_WAIT;
        end
        // Read bits are counted on host clock rises so the fetch fires once per byte
        if (sclk_rise && st_q.st == ST_READ && st_q.cnt != I2C_ACK_SLOT)
        begin
          st_d.cnt = st_q.cnt + 4'h1;
        end
        if (sclk_fall && st_q.cnt == I2C_ACK_SLOT)
        begin
          st_d.oe = st_q.ack;
          st_d.out = 1'b0;
        end
        else if (sclk_fall && st_q.cnt == 4'h0)
        begin
          st_d.ack = 1'b0;
          if (st_q.st != ST_READ)
            st_d.oe = 1'b0;
        end
        // Start and stop override the byte logic, but a select fall wins: a released
        // data line may wander while the clock idles high and must not spoil SPI entry
        if ((i2c_start || i2c_stop) && !sel_fall)
        begin
          st_d.st = i2c_start ? ST_ADDR : ST_IDLE;
          st_d.cnt = 4'h0;
          st_d.ack = 1'b0;
          st_d.oe = 1'b0;
        end
      end
    end
  end

  // State register; runs freely, the audio clocks never touch it
  always_ff @(posedge core_clk_i)
  begin
    st_q <= st_d;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign serial_data_out_o = st_q.out;
  assign serial_data_out_oe_o = st_q.oe;
  assign reg_addr_o = st_q.ptr[6:0];
  assign pointer_auto_advance_o = st_q.ptr[PTR_POINTER_AUTO_ADVANCE_BIT];
  assign reg_rd_o = st_q.rd;
  assign reg_wr_o = st_q.wr;
  assign reg_waddr_o = st_q.waddr;
  assign reg_wdata_o = st_q.wdata;
  assign spi_mode_o = st_q.spi;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_spi_drop;
    st_q.spi && sel_s;
  endsequence

  sequence s_first_fall;
    st_q.spi && tx_fall && st_q.cnt == 4'h0;
  endsequence

  sequence s_data_byte;
    st_q.spi && byte_done && st_q.st == ST_WDATA;
  endsequence

  a_select_abort: assert property (s_spi_drop |=> st_q.st == ST_ADDR && st_q.cnt == 4'h0 && !st_q.oe)
    else $error("select release did not abandon transfer");
  a_write_hiz: assert property (st_q.spi && st_q.st != ST_READ |-> !serial_data_out_oe_o)
    else $error("data output driven outside an SPI read");
  a_mode_lock: assert property ($rose(st_q.spi) |-> $past(st_q.sel_prev) && !$past(sel_s))
    else $error("SPI mode entered without select fall");
  a_mode_stay: assert property (st_q.spi |=> st_q.spi)
    else $error("SPI mode left without reset");
  a_read_msb: assert property (s_first_fall |=> serial_data_out_oe_o && reg_rd_o
                               && serial_data_out_o == $past(reg_rdata_i[7]))
    else $error("read MSB not driven on first fall");
  a_ptr_step: assert property (reg_wr_o |-> reg_addr_o ==
                               (pointer_auto_advance_o ? reg_waddr_o + 7'h01 : reg_waddr_o))
    else $error("pointer step wrong after write");
  a_spi_write: assert property (s_data_byte |=> reg_wr_o && reg_wdata_o == $past(rx_byte)
                                && reg_waddr_o == $past(st_q.ptr[6:0]))
    else $error("SPI data byte not written to pointed register");
  a_ack_drive: assert property (!st_q.spi && sclk_fall && st_q.cnt == I2C_ACK_SLOT && st_q.ack
                                |=> serial_data_out_oe_o && !serial_data_out_o)
    else $error("I2C acknowledge not driven");
  a_i2c_match: assert property (!st_q.spi && byte_done && st_q.st == ST_ADDR && !addr_match
                                |=> st_q.st == ST_WAIT && !st_q.ack)
    else $error("foreign I2C address answered");
  a_strap_hold: assert property ($fell(sys_rst_i) |-> st_q.a2 == $past(strap_s))
    else $error("strap not caught during reset");
  a_strap_keep: assert property (!$past(sys_rst_i) |-> $stable(st_q.a2))
    else $error("strap changed outside reset");
  a_i2c_fetch: assert property (!st_q.spi && tx_fall && st_q.cnt == 4'h0 |=> reg_rd_o)
    else $error("I2C read byte not fetched");

endmodule
`default_nettype wire

// file: sim/host_model.sv
// Host master model that drives the control port as SPI or I2C master
`timescale 1ns/1ns
`default_nettype none
module host_model (
  // Clock
  input wire logic core_clk_i,
  // Data pin level as the host sees it
  input wire logic data_wire_i,
  // Host-driven pins
  output logic sel_n_o,
  output logic sclk_o,
  output logic mosi_o,
  output logic sda_low_o
);
  // ****
  // Idle pins and bit timing
  // ****
  // Pins held static between transfers so the port sees no stray edges
  initial
  begin
    sel_n_o = 1'b1;
    sclk_o = 1'b1;
    mosi_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // Four core clocks are half of a 400 ns link bit
  task automatic half_bit();
    repeat (4) @(posedge core_clk_i);
  endtask
  // ****
  // SPI
  // ****
  task automatic spi_begin();
    sel_n_o <= 1'b0;
    half_bit();
  endtask
  task automatic spi_end();
    sel_n_o <= 1'b1;
    repeat (2) half_bit();
  endtask
  // MSB first; drive on the falling clock, sample just after the rising one
  task automatic spi_bits(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--)
    begin
      sclk_o <= 1'b0;
      mosi_o <= tx[i];
      half_bit();
      sclk_o <= 1'b1;
      #1 rx[i] = data_wire_i;
      half_bit();
    end
  endtask
  // ****
  // I2C
  // ****
  // Start and stop move data while the clock is high
  task automatic i2c_start();
    sda_low_o <= 1'b1;
    half_bit();
    sclk_o <= 1'b0;
    half_bit();
  endtask
  task automatic i2c_stop();
    sda_low_o <= 1'b1;
    half_bit();
    sclk_o <= 1'b1;
    half_bit();
    sda_low_o <= 1'b0;
    half_bit();
  endtask
  // Data moves one clock after the fall, leaving hold time past the clock edge
  task automatic i2c_bit(input logic b, output logic r);
    sda_low_o <= ~b;
    repeat (3) @(posedge core_clk_i);
    sclk_o <= 1'b1;
    #1 r = data_wire_i;
    half_bit();
    sclk_o <= 1'b0;
    @(posedge core_clk_i);
  endtask
  // Byte MSB first, then the acknowledge slot; host answers with ack_in
  task automatic i2c_byte(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      i2c_bit(tx[i], r);
      rx[i] = r;
    end
    i2c_bit(ack_in, ack);
  endtask
endmodule
`default_nettype wire

// file: sim/dual_mode_control_port_tb_top.sv
// Self-checking testbench for the dual-mode control port
`timescale 1ns/1ns
`default_nettype none
module dual_mode_control_port_tb_top;
  // ****
  // Signals, register file and pin wiring
  // ****
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic strap = 1'b0;
  logic i2c_phase = 1'b0;
  logic wr_frame = 1'b0;
  logic tog = 1'b0;
  logic sel_n, sclk, mosi, sda_low, data_wire, sdo, sdo_oe, auto_adv, rd_p, wr_p, spi_mode;
  logic [6:0] raddr, waddr;
  logic [7:0] wdata, rdata;
  logic [7:0] regs [128];
  int n_mismatch = 0;
  int checked = 0;
  // Pull-up in I2C; a released SPI output shows a changing pattern, never its last bit
  assign data_wire = i2c_phase ? ~((sdo_oe & ~sdo) | sda_low) : (sdo_oe ? sdo : tog);
  assign rdata = regs[raddr];
  always @(posedge core_clk_i)
  begin
    tog <= ~tog;
    if (wr_p === 1'b1)
      regs[waddr] <= wdata;
    if (wr_frame)
      chk_bit(sdo_oe, 1'b0);
  end
  initial
  begin
    forever #25 core_clk_i = ~core_clk_i;
  end
  dual_mode_control_port dual_mode_control_port_i (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .select_or_addr_bit0_pin_i(sel_n), .serial_bit_clock_i(sclk), .serial_data_in_i(mosi),
    .serial_data_out_i(data_wire), .serial_data_out_o(sdo), .serial_data_out_oe_o(sdo_oe),
    .addr_bit1_pin_i(1'b0), .preemphasis_strap_pin_i(strap), .reg_addr_o(raddr),
    .pointer_auto_advance_o(auto_adv), .reg_rdata_i(rdata), .reg_rd_o(rd_p), .reg_wr_o(wr_p),
    .reg_waddr_o(waddr), .reg_wdata_o(wdata), .spi_mode_o(spi_mode));
  host_model host_model_i (.core_clk_i(core_clk_i), .data_wire_i(data_wire), .sel_n_o(sel_n),
    .sclk_o(sclk), .mosi_o(mosi), .sda_low_o(sda_low));
  // ****
  // Compare, reset and transfer helpers
  // ****
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask
  task automatic close_out();
    if (n_mismatch == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Strap flips at release, so only a value caught during reset can match
  task automatic do_reset(input logic s);
    sys_rst_i <= 1'b1;
    strap <= s;
    repeat (4) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    strap <= ~s;
    repeat (2) @(posedge core_clk_i);
  endtask
  task automatic ic(input logic [7:0] tx, input logic hack, input logic [7:0] exp, input logic eack);
    logic [7:0] rx;
    logic ack;
    host_model_i.i2c_byte(tx, hack, rx, ack);
    chk_byte(rx, exp);
    chk_bit(ack, eack);
  endtask
  task automatic spi_tx(input logic [7:0] q [$]);
    logic [7:0] rx;
    host_model_i.spi_begin();
    foreach (q[i])
      host_model_i.spi_bits(q[i], 8, rx);
    host_model_i.spi_end();
  endtask
  task automatic spi_rd(input logic [7:0] ptr, input logic [7:0] e [$]);
    logic [7:0] rx;
    spi_tx('{8'h20, ptr});
    host_model_i.spi_begin();
    host_model_i.spi_bits(8'h21, 8, rx);
    foreach (e[i])
    begin
      host_model_i.spi_bits(8'hFF, 8, rx);
      chk_byte(rx, e[i]);
    end
    host_model_i.spi_end();
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_i2c();
    i2c_phase <= 1'b1;
    do_reset(1'b1);
    host_model_i.i2c_start();
    ic(8'h2A, 1'b1, 8'h2A, 1'b0);
    ic(8'h82, 1'b1, 8'h82, 1'b0);
    ic(8'hA5, 1'b1, 8'hA5, 1'b0);
    ic(8'h3C, 1'b1, 8'h3C, 1'b0);
    host_model_i.i2c_stop();
    host_model_i.i2c_start();
    ic(8'h2A, 1'b1, 8'h2A, 1'b0);
    ic(8'h82, 1'b1, 8'h82, 1'b0);
    host_model_i.i2c_stop();
    host_model_i.i2c_start();
    ic(8'h2B, 1'b1, 8'h2B, 1'b0);
    ic(8'hFF, 1'b0, 8'hA5, 1'b0);
    ic(8'hFF, 1'b1, 8'h3C, 1'b1);
    host_model_i.i2c_stop();
    host_model_i.i2c_start();
    ic(8'h22, 1'b1, 8'h22, 1'b1);
    host_model_i.i2c_stop();
    chk_byte(regs[2], 8'hA5);
    chk_byte(regs[3], 8'h3C);
    chk_bit(spi_mode, 1'b0);
  endtask
  task automatic t_spi_write();
    i2c_phase <= 1'b0;
    do_reset(1'b0);
    wr_frame <= 1'b1;
    spi_tx('{8'h20, 8'h83, 8'h11, 8'h22, 8'h33});
    spi_tx('{8'h20, 8'h07, 8'h44, 8'h55});
    wr_frame <= 1'b0;
    chk_bit(spi_mode, 1'b1);
    chk_byte(regs[3], 8'h11);
    chk_byte(regs[5], 8'h33);
    chk_byte(regs[7], 8'h55);
    chk_byte(regs[8], 8'h00);
  endtask
  task automatic t_spi_read();
    spi_rd(8'h83, '{8'h11, 8'h22, 8'h33});
    chk_bit(auto_adv, 1'b1);
    chk_byte({1'b0, raddr}, 8'h06);
    spi_rd(8'h07, '{8'h55, 8'h55});
    chk_bit(auto_adv, 1'b0);
    chk_byte({1'b0, raddr}, 8'h07);
  endtask
  // Select released mid-byte, then a frame for another chip, then a clean frame
  task automatic t_spi_abort();
    logic [7:0] rx;
    wr_frame <= 1'b1;
    host_model_i.spi_begin();
    host_model_i.spi_bits(8'h20, 8, rx);
    host_model_i.spi_bits(8'h09, 8, rx);
    host_model_i.spi_bits(8'hF0, 4, rx);
    host_model_i.spi_end();
    spi_tx('{8'h24, 8'h0A, 8'h77});
    spi_tx('{8'h20, 8'h0B, 8'h66});
    wr_frame <= 1'b0;
    chk_byte(regs[9], 8'h00);
    chk_byte(regs[10], 8'h00);
    chk_byte(regs[11], 8'h66);
  endtask
  initial
  begin
    for (int i = 0; i < 128; i++)
      regs[i] = 8'h00;
    t_i2c();
    t_spi_write();
    t_spi_read();
    t_spi_abort();
    close_out();
  end
  // A hang counts as a mismatch and ends the run
  initial
  begin
    #4000000;
    n_mismatch++;
    close_out();
  end
endmodule
`default_nettype wire
